/* File: rtl/pseb_pkg.sv */
// constants, offsets and state types for the configuration status error bits
package pseb_pkg;

	// configuration space byte offsets
	localparam logic [11:0] PSEB_CMD_OFS          = 12'h004;
	localparam logic [11:0] PSEB_PRI_STATUS_OFS   = 12'h006;
	localparam logic [11:0] PSEB_SEC_STATUS_OFS   = 12'h01E;
	localparam logic [11:0] PSEB_BRIDGE_CTRL_OFS  = 12'h03E;

	// dword addresses used on the configuration port
	localparam int          PSEB_DWADDR_W         = 10;
	localparam logic [9:0]  PSEB_DW_CMD_STATUS    = 10'(PSEB_CMD_OFS >> 2);
	localparam logic [9:0]  PSEB_DW_SEC_STATUS    = 10'(PSEB_SEC_STATUS_OFS >> 2);
	localparam logic [9:0]  PSEB_DW_BRIDGE_CTRL   = 10'(PSEB_BRIDGE_CTRL_OFS >> 2);

	// command register fields
	localparam int          PSEB_CMD_PARITY_BIT   = 6;
	localparam int          PSEB_CMD_SERR_BIT     = 8;
	// bridge control fields
	localparam int          PSEB_BCTL_PARITY_BIT  = 0;
	localparam int          PSEB_BCTL_SERR_BIT    = 1;

	// status word fields; the error bits are shared by primary and secondary words, bits 3 and 4 are primary only
	localparam int          PSEB_ST_INTR_BIT      = 3;
	localparam int          PSEB_ST_CAPLIST_BIT   = 4;
	localparam int          PSEB_ST_MDPE_BIT      = 8;
	localparam int          PSEB_ST_STA_BIT       = 11;
	localparam int          PSEB_ST_RTA_BIT       = 12;
	localparam int          PSEB_ST_RMA_BIT       = 13;
	localparam int          PSEB_ST_SSE_BIT       = 14;
	localparam int          PSEB_ST_DPE_BIT       = 15;
	localparam int          PSEB_NUM_ERR_BITS     = 6;

	// reset values
	localparam logic        PSEB_ERR_BIT_RST      = 1'b0;
	localparam logic        PSEB_CTRL_BIT_RST     = 1'b0;
	localparam logic [31:0] PSEB_RDATA_RST        = 32'h0000_0000;

	typedef struct packed {
		logic value;
	} pseb_bit_state_t;

	typedef struct packed {
		logic        cmd_parity_resp;
		logic        cmd_serr_en;
		logic        sec_parity_resp;
		logic        sec_serr_en;
		logic        intr_status;
		logic        done;
		logic [31:0] rdata;
	} pseb_state_t;

endpackage : pseb_pkg

/* File: rtl/pseb_sticky_bit.sv */
// one write-one-to-clear error bit, set by hardware events
`timescale 1ns/1ps
module pseb_sticky_bit (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic ce,
	input  wire logic set_evt,
	input  wire logic clr_req,
	output logic      value
);
	import pseb_pkg::*;

	pseb_bit_state_t state_reg;
	pseb_bit_state_t state_next;

	always_comb begin
		state_next = state_reg;
		// set wins so an event in the clearing cycle is not lost
		if (set_evt) begin
			state_next.value = 1'b1; // [RULE22]
		end else if (clr_req) begin
			state_next.value = 1'b0; // [RULE22]
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg.value <= PSEB_ERR_BIT_RST;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	assign value = state_reg.value;

endmodule : pseb_sticky_bit

/* File: rtl/pseb_status_bits.sv */
// status and secondary status error bits with configuration port access
// What this block does
// [RULE1] endpoint interrupt status follows user interrupt, read-only
// [RULE2] reserved bits read zero, capability bit one
// [RULE3] endpoint parity bit: poisoned completion in or write out
// [RULE4] endpoint signaled abort on user completer abort
// [RULE5] endpoint received abort on abort completion
// [RULE6] endpoint master abort on unsupported request completion
// [RULE7] endpoint system error: error message sent, enabled
// [RULE8] endpoint detected parity on any poisoned receive
// [RULE9] root port interrupt status bit unused
// [RULE10] root port parity bit: poisoned completion received only
// [RULE11] root port never sets bits 11 to 13
// [RULE12] root port: error message received, both enables
// [RULE13] root port: message port error upstream, enabled
// [RULE14] root port detected parity on poisoned transmit
// [RULE15] secondary parity bit, secondary response enabled
// [RULE16] secondary signaled abort on user abort indication
// [RULE17] secondary received abort on abort completion
// [RULE18] secondary master abort on unsupported completion
// [RULE19] secondary system error on received error message
// [RULE20] secondary detected parity on any poisoned receive
// [RULE21] parity response enable is command bit six
// [RULE22] error bits sticky until software writes one
`timescale 1ns/1ps
module pseb_status_bits #(
	parameter bit ROOT_PORT    = 1'b0,
	parameter int DWADDR_WIDTH = pseb_pkg::PSEB_DWADDR_W
) (
	input  wire logic                      clk,
	input  wire logic                      rstn,
	input  wire logic                      ce,
	// configuration port
	input  wire logic                      cfg_rd_en,
	input  wire logic                      cfg_wr_en,
	input  wire logic [DWADDR_WIDTH-1:0]   cfg_dwaddr,
	input  wire logic [31:0]               cfg_di,
	input  wire logic [3:0]                cfg_byte_en,
	output logic [31:0]                    cfg_do,
	output logic                           cfg_rd_wr_done,
	// link side events, one-cycle pulses
	input  wire logic                      rx_poisoned_cpl,
	input  wire logic                      rx_poisoned_tlp,
	input  wire logic                      tx_poisoned_wr,
	input  wire logic                      tx_poisoned_tlp,
	input  wire logic                      rx_cpl_abort,
	input  wire logic                      rx_cpl_unsupported,
	input  wire logic                      rx_err_msg,
	input  wire logic                      tx_err_msg,
	// user side events
	input  wire logic                      user_cpl_abort,
	input  wire logic                      msg_err_upstream,
	input  wire logic                      user_intr_assert,
	input  wire logic                      user_intr_clear,
	// control state seen by the rest of the core
	output logic                           parity_error_response,
	output logic                           system_error_report_enable,
	output logic                           sec_parity_error_response,
	output logic                           sec_system_error_report_enable
);
	import pseb_pkg::*;

	// the decode needs at least the bridge control dword
	initial begin
		if (DWADDR_WIDTH < 4 || DWADDR_WIDTH > 10) begin
			$error("pseb_status_bits: DWADDR_WIDTH must be 4 to 10");
		end
	end

	localparam logic [DWADDR_WIDTH-1:0] DW_CMD  = DWADDR_WIDTH'(PSEB_DW_CMD_STATUS);
	localparam logic [DWADDR_WIDTH-1:0] DW_SEC  = DWADDR_WIDTH'(PSEB_DW_SEC_STATUS);
	localparam logic [DWADDR_WIDTH-1:0] DW_BCTL = DWADDR_WIDTH'(PSEB_DW_BRIDGE_CTRL);

	// error bit positions in the order of the sticky instances
	localparam int ERR_POS [PSEB_NUM_ERR_BITS] = '{
		PSEB_ST_MDPE_BIT, PSEB_ST_STA_BIT, PSEB_ST_RTA_BIT,
		PSEB_ST_RMA_BIT, PSEB_ST_SSE_BIT, PSEB_ST_DPE_BIT
	};

	// reset release through two flops
	logic rst_meta_reg;
	logic rst_sync_reg;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	pseb_state_t state_reg;
	pseb_state_t state_next;

	logic                         take;
	logic                         take_wr;
	logic [PSEB_NUM_ERR_BITS-1:0] pri_set;
	logic [PSEB_NUM_ERR_BITS-1:0] sec_set;
	logic [PSEB_NUM_ERR_BITS-1:0] pri_clr;
	logic [PSEB_NUM_ERR_BITS-1:0] sec_clr;
	logic [PSEB_NUM_ERR_BITS-1:0] pri_val;
	logic [PSEB_NUM_ERR_BITS-1:0] sec_val;
	logic [15:0]                  pri_word;
	logic [15:0]                  sec_word;
	logic [15:0]                  cmd_word;
	logic [15:0]                  bctl_word;

	// a held request is taken every other cycle; done blocks only the cycle after each take
	assign take    = (cfg_rd_en || cfg_wr_en) && !state_reg.done;
	assign take_wr = take && cfg_wr_en;

	// primary status set conditions
	always_comb begin
		pri_set = '0;
		if (!ROOT_PORT) begin
			pri_set[0] = state_reg.cmd_parity_resp && (rx_poisoned_cpl || tx_poisoned_wr); // [RULE3] [RULE21]
			pri_set[1] = user_cpl_abort;                                                  // [RULE4]
			pri_set[2] = rx_cpl_abort;                                                    // [RULE5]
			pri_set[3] = rx_cpl_unsupported;                                              // [RULE6]
			pri_set[4] = tx_err_msg && state_reg.cmd_serr_en;                             // [RULE7]
			pri_set[5] = rx_poisoned_tlp;                                                 // [RULE8]
		end else begin
			pri_set[0] = state_reg.cmd_parity_resp && rx_poisoned_cpl;                    // [RULE10] [RULE21]
			// bits 11 to 13 stay clear in a root port
			pri_set[1] = 1'b0;                                                            // [RULE11]
			pri_set[2] = 1'b0;                                                            // [RULE11]
			pri_set[3] = 1'b0;                                                            // [RULE11]
			pri_set[4] = (rx_err_msg && state_reg.cmd_serr_en && state_reg.sec_serr_en)   // [RULE12]
				|| (msg_err_upstream && state_reg.cmd_serr_en);                           // [RULE13]
			pri_set[5] = tx_poisoned_tlp;                                                 // [RULE14]
		end
	end

	// secondary status exists only in a root port
	always_comb begin
		sec_set = '0;
		if (ROOT_PORT) begin
			sec_set[0] = state_reg.sec_parity_resp && (rx_poisoned_cpl || tx_poisoned_wr); // [RULE15]
			sec_set[1] = user_cpl_abort;                                                  // [RULE16]
			sec_set[2] = rx_cpl_abort;                                                    // [RULE17]
			sec_set[3] = rx_cpl_unsupported;                                              // [RULE18]
			sec_set[4] = rx_err_msg;                                                      // [RULE19]
			sec_set[5] = rx_poisoned_tlp;                                                 // [RULE20]
		end
	end

	// write-one-to-clear; status words sit in the upper two byte lanes
	always_comb begin
		pri_clr = '0;
		sec_clr = '0;
		for (int i = 0; i < PSEB_NUM_ERR_BITS; i++) begin
			if (take_wr && cfg_dwaddr == DW_CMD && cfg_byte_en[2 + ERR_POS[i] / 8]) begin
				pri_clr[i] = cfg_di[16 + ERR_POS[i]]; // [RULE22]
			end
			if (take_wr && cfg_dwaddr == DW_SEC && cfg_byte_en[2 + ERR_POS[i] / 8] && ROOT_PORT) begin
				sec_clr[i] = cfg_di[16 + ERR_POS[i]]; // [RULE22]
			end
		end
	end

	for (genvar g = 0; g < PSEB_NUM_ERR_BITS; g++) begin : g_err
		pseb_sticky_bit u_pri (
			.clk     (clk),
			.rst_n   (rst_sync_reg),
			.ce      (ce),
			.set_evt (pri_set[g]),
			.clr_req (pri_clr[g]),
			.value   (pri_val[g])
		);
		pseb_sticky_bit u_sec (
			.clk     (clk),
			.rst_n   (rst_sync_reg),
			.ce      (ce),
			.set_evt (sec_set[g]),
			.clr_req (sec_clr[g]),
			.value   (sec_val[g])
		);
	end

	// assemble read words; everything not named reads zero
	always_comb begin
		pri_word = '0;
		sec_word = '0;
		pri_word[PSEB_ST_CAPLIST_BIT] = 1'b1;                          // [RULE2]
		pri_word[PSEB_ST_INTR_BIT]    = ROOT_PORT ? 1'b0 : state_reg.intr_status; // [RULE1] [RULE9]
		for (int i = 0; i < PSEB_NUM_ERR_BITS; i++) begin
			pri_word[ERR_POS[i]] = pri_val[i];
			sec_word[ERR_POS[i]] = sec_val[i];                         // [RULE2]
		end
		cmd_word                        = '0;
		cmd_word[PSEB_CMD_PARITY_BIT]   = state_reg.cmd_parity_resp;
		cmd_word[PSEB_CMD_SERR_BIT]     = state_reg.cmd_serr_en;
		bctl_word                       = '0;
		bctl_word[PSEB_BCTL_PARITY_BIT] = state_reg.sec_parity_resp;
		bctl_word[PSEB_BCTL_SERR_BIT]   = state_reg.sec_serr_en;
	end

	always_comb begin
		state_next      = state_reg;
		state_next.done = take;

		// interrupt status: assertion wins over a clear in the same cycle
		if (ROOT_PORT) begin
			state_next.intr_status = 1'b0;                             // [RULE9]
		end else if (user_intr_assert) begin
			state_next.intr_status = 1'b1;                             // [RULE1]
		end else if (user_intr_clear) begin
			state_next.intr_status = 1'b0;                             // [RULE1]
		end

		// control bits, honouring byte enables
		if (take_wr && cfg_dwaddr == DW_CMD) begin
			if (cfg_byte_en[PSEB_CMD_PARITY_BIT / 8]) begin
				state_next.cmd_parity_resp = cfg_di[PSEB_CMD_PARITY_BIT]; // [RULE21]
			end
			if (cfg_byte_en[PSEB_CMD_SERR_BIT / 8]) begin
				state_next.cmd_serr_en = cfg_di[PSEB_CMD_SERR_BIT];
			end
		end else if (take_wr && cfg_dwaddr == DW_BCTL && ROOT_PORT) begin
			if (cfg_byte_en[2]) begin
				state_next.sec_parity_resp = cfg_di[16 + PSEB_BCTL_PARITY_BIT];
				state_next.sec_serr_en     = cfg_di[16 + PSEB_BCTL_SERR_BIT];
			end
		end

		// read data; a write returns zero on the data lines
		if (take && cfg_rd_en && !cfg_wr_en) begin
			if (cfg_dwaddr == DW_CMD) begin
				state_next.rdata = {pri_word, cmd_word};
			end else if (cfg_dwaddr == DW_SEC && ROOT_PORT) begin
				state_next.rdata = {sec_word, 16'h0000};               // [RULE2]
			end else if (cfg_dwaddr == DW_BCTL && ROOT_PORT) begin
				state_next.rdata = {bctl_word, 16'h0000};
			end else begin
				state_next.rdata = 32'h0000_0000;
			end
		end else if (take) begin
			state_next.rdata = 32'h0000_0000;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_reg) begin
		if (!rst_sync_reg) begin
			state_reg.cmd_parity_resp <= PSEB_CTRL_BIT_RST;
			state_reg.cmd_serr_en     <= PSEB_CTRL_BIT_RST;
			state_reg.sec_parity_resp <= PSEB_CTRL_BIT_RST;
			state_reg.sec_serr_en     <= PSEB_CTRL_BIT_RST;
			state_reg.intr_status     <= PSEB_ERR_BIT_RST;
			state_reg.done            <= 1'b0;
			state_reg.rdata           <= PSEB_RDATA_RST;
		end else if (ce) begin
			state_reg <= state_next;
		end
	end

	assign cfg_do                         = state_reg.rdata;
	assign cfg_rd_wr_done                 = state_reg.done;
	assign parity_error_response          = state_reg.cmd_parity_resp;
	assign system_error_report_enable     = state_reg.cmd_serr_en;
	assign sec_parity_error_response      = state_reg.sec_parity_resp;
	assign sec_system_error_report_enable = state_reg.sec_serr_en;

endmodule : pseb_status_bits

/* File: tb/pseb_status_bits_asserts.sv */
// checker for the status error bits readout and enables
`timescale 1ns/1ps
module pseb_status_bits_asserts #(
	parameter bit ROOT_PORT    = 1'b0,
	parameter int DWADDR_WIDTH = 10
) (
	input wire logic                    clk,
	input wire logic                    rstn,
	input wire logic                    ce,
	input wire logic                    cfg_rd_en,
	input wire logic                    cfg_wr_en,
	input wire logic [DWADDR_WIDTH-1:0] cfg_dwaddr,
	input wire logic [31:0]             cfg_di,
	input wire logic [3:0]              cfg_byte_en,
	input wire logic [31:0]             cfg_do,
	input wire logic                    cfg_rd_wr_done,
	input wire logic                    rx_poisoned_tlp,
	input wire logic                    tx_poisoned_tlp,
	input wire logic                    rx_err_msg,
	input wire logic                    parity_error_response
);
	logic rd1;
	logic rd7;
	// a write wins over a read, so reads count only with write low
	assign rd1 = ce && cfg_rd_en && !cfg_wr_en && !cfg_rd_wr_done && cfg_dwaddr == 10'h001;
	assign rd7 = ce && cfg_rd_en && !cfg_wr_en && !cfg_rd_wr_done && cfg_dwaddr == 10'h007;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	AST_CAP_RSVD: assert property (rd1 |=> cfg_do[20] && (cfg_do[26:16] & 11'h6E7) == 11'h000)
		else $error("status reserved or capability bit wrong");
	AST_SEC_RSVD: assert property (rd7 |=> cfg_do[23:0] == 24'h000000 && cfg_do[26:25] == 2'h0)
		else $error("secondary reserved bits not zero");
	AST_RP_NO_ABORT: assert property (ROOT_PORT && rd1 |=> cfg_do[29:27] == 3'h0)
		else $error("root port abort bit set");
	AST_RP_INTR: assert property (ROOT_PORT && rd1 |=> !cfg_do[19])
		else $error("root port interrupt status set");
	AST_SEC_DPE: assert property (ROOT_PORT && $past(ce && rx_poisoned_tlp) && rd7 |=> cfg_do[31])
		else $error("secondary detected parity missing");
	AST_SEC_SSE: assert property (ROOT_PORT && $past(ce && rx_err_msg) && rd7 |=> cfg_do[30])
		else $error("secondary system error missing");
	AST_PRI_DPE: assert property (ROOT_PORT && $past(ce && tx_poisoned_tlp) && rd1 |=> cfg_do[31])
		else $error("root port detected parity missing");
	AST_PAR_EN: assert property (ce && cfg_wr_en && !cfg_rd_wr_done && cfg_dwaddr == 10'h001 && cfg_byte_en[0]
		|=> parity_error_response == $past(cfg_di[6])) else $error("parity response enable not stored");
	CV_RD7: cover property (rd7 ##1 cfg_do[31]);
	CV_WR: cover property (ce && cfg_wr_en && !cfg_rd_wr_done);
	CV_SSE: cover property (rd1 ##1 cfg_do[30]);
endmodule : pseb_status_bits_asserts

bind pseb_status_bits pseb_status_bits_asserts #(.ROOT_PORT(ROOT_PORT), .DWADDR_WIDTH(DWADDR_WIDTH)) u_chk (
	.clk(clk), .rstn(rstn), .ce(ce), .cfg_rd_en(cfg_rd_en), .cfg_wr_en(cfg_wr_en), .cfg_dwaddr(cfg_dwaddr),
	.cfg_di(cfg_di), .cfg_byte_en(cfg_byte_en), .cfg_do(cfg_do), .cfg_rd_wr_done(cfg_rd_wr_done),
	.rx_poisoned_tlp(rx_poisoned_tlp), .tx_poisoned_tlp(tx_poisoned_tlp), .rx_err_msg(rx_err_msg),
	.parity_error_response(parity_error_response));

/* File: tb/pseb_far_model.sv */
// link partner and user logic event source, one-cycle pulses
`timescale 1ns/1ps
module pseb_far_model (
	input  wire logic        clk,
	input  wire logic [11:0] fire,
	output logic      [11:0] evt
);
	initial evt = 12'h000;
	// registered so an event moves only on the edge the design samples
	always @(posedge clk) begin
		evt <= fire;
	end
endmodule : pseb_far_model

/* File: tb/pseb_status_bits_tb.sv */
// self-checking bench for the status error bits, root port and endpoint builds side by side
`timescale 1ns/1ps
module pseb_status_bits_tb;
	import pseb_pkg::*;
	logic        clk, rstn, ce, rd_en, wr_en, done;
	logic [9:0]  addr;
	logic [31:0] di, dout, rdv, dout_ep, rdv_ep;
	logic [3:0]  be, en_seen, en_ep;
	logic        done_ep;
	logic [11:0] fire, evt;
	int          bad_count, checked, cyc;
	initial clk = 1'b0;
	always #5 clk = ~clk;
	pseb_far_model u_far (.clk(clk), .fire(fire), .evt(evt));
	pseb_status_bits #(.ROOT_PORT(1'b1), .DWADDR_WIDTH(10)) u_dut (
		.clk(clk), .rstn(rstn), .ce(ce), .cfg_rd_en(rd_en), .cfg_wr_en(wr_en), .cfg_dwaddr(addr),
		.cfg_di(di), .cfg_byte_en(be), .cfg_do(dout), .cfg_rd_wr_done(done),
		.rx_poisoned_cpl(evt[0]), .rx_poisoned_tlp(evt[1]), .tx_poisoned_wr(evt[2]), .tx_poisoned_tlp(evt[3]),
		.rx_cpl_abort(evt[4]), .rx_cpl_unsupported(evt[5]), .rx_err_msg(evt[6]), .tx_err_msg(evt[7]),
		.user_cpl_abort(evt[8]), .msg_err_upstream(evt[9]), .user_intr_assert(evt[10]),
		.user_intr_clear(evt[11]), .parity_error_response(en_seen[0]), .system_error_report_enable(en_seen[1]),
		.sec_parity_error_response(en_seen[2]), .sec_system_error_report_enable(en_seen[3]));
	// endpoint build sees the same requests and events, so its done pulse lines up with the root port's
	pseb_status_bits #(.ROOT_PORT(1'b0), .DWADDR_WIDTH(10)) u_dut_ep (
		.clk(clk), .rstn(rstn), .ce(ce), .cfg_rd_en(rd_en), .cfg_wr_en(wr_en), .cfg_dwaddr(addr),
		.cfg_di(di), .cfg_byte_en(be), .cfg_do(dout_ep), .cfg_rd_wr_done(done_ep),
		.rx_poisoned_cpl(evt[0]), .rx_poisoned_tlp(evt[1]), .tx_poisoned_wr(evt[2]), .tx_poisoned_tlp(evt[3]),
		.rx_cpl_abort(evt[4]), .rx_cpl_unsupported(evt[5]), .rx_err_msg(evt[6]), .tx_err_msg(evt[7]),
		.user_cpl_abort(evt[8]), .msg_err_upstream(evt[9]), .user_intr_assert(evt[10]),
		.user_intr_clear(evt[11]), .parity_error_response(en_ep[0]), .system_error_report_enable(en_ep[1]),
		.sec_parity_error_response(en_ep[2]), .sec_system_error_report_enable(en_ep[3]));
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	// done is sampled at the falling edge, so the drop lands while done still refuses
	task automatic wait_done();
		int n;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (done !== 1'b1 && n < 20);
		if (done !== 1'b1) chk("done", 32'h0, 32'h1);
	endtask : wait_done
	task automatic cfg_rd(input logic [9:0] a, output logic [31:0] d);
		@(posedge clk);
		rd_en <= 1'b1;
		addr <= a;
		wait_done();
		d = dout;
		rdv_ep = dout_ep;
		chk("ep_done", {31'h0, done_ep}, 32'h1);
		@(posedge clk);
		rd_en <= 1'b0;
	endtask : cfg_rd
	task automatic cfg_wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] b);
		@(posedge clk);
		wr_en <= 1'b1;
		addr <= a;
		di <= d;
		be <= b;
		wait_done();
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : cfg_wr
	task automatic pulse(input int ev);
		@(posedge clk);
		fire <= 12'h001 << ev;
		@(posedge clk);
		fire <= 12'h000;
	endtask : pulse
	// m: bit0 parity resp, bit1 system error, bit2 sec parity, bit3 sec system error
	function automatic logic [31:0] expect_bits(input int ev, input logic [3:0] m);
		logic [15:0] p, s;
		p = 16'h0010;
		s = 16'h0000;
		p[8] = (ev == 0) && m[0];
		p[14] = (ev == 6 && m[1] && m[3]) || (ev == 9 && m[1]);
		p[15] = (ev == 3);
		s[8] = (ev == 0 || ev == 2) && m[2];
		s[11] = (ev == 8);
		s[12] = (ev == 4);
		s[13] = (ev == 5);
		s[14] = (ev == 6);
		s[15] = (ev == 1);
		return {s, p};
	endfunction : expect_bits
	// endpoint primary status after event ev under mode m
	function automatic logic [15:0] expect_ep(input int ev, input logic [3:0] m);
		logic [15:0] p;
		p = 16'h0010;
		p[3] = (ev == 10);
		p[8] = (ev == 0 || ev == 2) && m[0];
		p[11] = (ev == 8);
		p[12] = (ev == 4);
		p[13] = (ev == 5);
		p[14] = (ev == 7) && m[1];
		p[15] = (ev == 1);
		return p;
	endfunction : expect_ep
	task automatic read_both(input logic [31:0] e, input logic [15:0] cmd, input logic [15:0] ep);
		cfg_rd(10'h001, rdv);
		chk("status_cmd", rdv, {e[15:0], cmd});
		chk("ep_status_cmd", rdv_ep, {ep, cmd});
		cfg_rd(10'h007, rdv);
		chk("sec_status", rdv, {e[31:16], 16'h0000});
		chk("ep_sec_status", rdv_ep, 32'h0000_0000);
	endtask : read_both
	task automatic t_reset();
		read_both(32'h0000_0010, 16'h0000, 16'h0010);
		cfg_rd(10'h002, rdv);
		chk("unmapped", rdv, 32'h0000_0000);
		$display("test reset values finished");
	endtask : t_reset
	task automatic t_mode(input logic [3:0] m);
		logic [15:0] cmd;
		logic [31:0] e;
		logic [15:0] ep;
		cmd = {7'h00, m[1], 1'b0, m[0], 6'h00};
		cfg_wr(10'h001, {16'h0000, cmd}, 4'h3);
		cfg_wr(10'h00F, {14'h0000, m[3], m[2], 16'h0000}, 4'hC);
		chk("enables", {28'h0, en_seen}, {28'h0, m});
		chk("ep_enables", {28'h0, en_ep}, {30'h0, m[1:0]});
		for (int ev = 0; ev < 12; ev++) begin
			pulse(ev);
			e = expect_bits(ev, m);
			ep = expect_ep(ev, m);
			read_both(e, cmd, ep);
			cfg_wr(10'h001, {16'h0000, cmd}, 4'hF);
			cfg_wr(10'h007, 32'h0000_0000, 4'hC);
			read_both(e, cmd, ep);
			cfg_wr(10'h001, {16'hFFFF, cmd}, 4'hF);
			cfg_wr(10'h007, 32'hFFFF_0000, 4'hC);
			read_both(32'h0000_0010, cmd, ep & 16'h0018);
		end
		$display("test events under mode %h finished", m);
	endtask : t_mode
	task automatic finish_test();
		$display("counts: checked %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : finish_test
	initial begin
		rstn = 1'b0;
		ce = 1'b1;
		rd_en = 1'b0;
		wr_en = 1'b0;
		addr = 10'h000;
		di = 32'h0000_0000;
		be = 4'h0;
		fire = 12'h000;
		bad_count = 0;
		checked = 0;
		cyc = 0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		t_reset();
		t_mode(4'h0);
		t_mode(4'hF);
		t_mode(4'h2);
		finish_test();
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			bad_count++;
			finish_test();
		end
	end
endmodule : pseb_status_bits_tb
